// ===== rtl/external_bus_config.sv
// The implementer's own choice: the Wishbone slave port.
module external_bus_config (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic hw_long_reset,
   input wire logic external_access_pin,
   input wire logic [15:0] config_port,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic req_valid,
   input wire logic [23:0] req_addr,
   input wire logic req_we,
   input wire logic [1:0] req_be,
   input wire logic [15:0] req_wdata,
   output logic req_ready,
   output logic req_done,
   output logic req_err,
   output logic [15:0] req_rdata,
   input wire logic ready_pin,
   input wire logic [15:0] ad_in,
   output logic [15:0] ad_out,
   output logic ad_oe,
   output logic [23:0] addr_out,
   output logic ale,
   output logic rd_n,
   output logic wr_n,
   output logic bhe_n,
   output logic [4:0] cs_n,
   output logic bus_wide,
   output logic bus_mux,
   output logic [5:0] cpu_clock_x2
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      ebc_pkg::bus_cfg_t prim;
      ebc_pkg::bus_cfg_t win4;
      logic [7:0] win4_base;
      ebc_pkg::reset_cfg_t rcfg;
      logic [5:0] clk_x2;
      logic [1:0] ea_s;
      logic [1:0][15:0] p0_s;
      logic [1:0] rdy_s;
      ebc_pkg::phase_t phase;
      logic [3:0] cnt;
      logic [23:0] addr;
      logic we;
      logic [1:0] be;
      logic [15:0] wdata;
      logic hit4;
      logic wide;
      logic mux;
      logic ready;
      logic done;
      logic err;
      logic [15:0] rdata;
      logic ale;
      logic rd_n;
      logic wr_n;
      logic bhe_n;
      logic [4:0] cs_n;
      logic [23:0] addr_o;
      logic [15:0] ad_o;
      logic ad_oe;
   } st_t;

   st_t st_ff;
   st_t nxt_st;
   logic req_hit4;
   logic sel_hit4;
   ebc_pkg::bus_cfg_t cur_cfg;
   logic rdy_act;
   logic strobe_end;
   logic bus_sel;

   function automatic ebc_pkg::bus_cfg_t put_cfg(input ebc_pkg::bus_cfg_t old,
                                                  input logic [31:0] d,
                                                  input logic [3:0] sel);
      logic [15:0] v;
      v = old;
      if (sel[0])
      begin
         v[7:0] = d[7:0];
      end
      if (sel[1])
      begin
         v[15:8] = d[15:8];
      end
      return ebc_pkg::bus_cfg_t'(v & ebc_pkg::CFG_MASK);
   endfunction

   // Lines beyond the enabled count stay high whatever the window asks for
   function automatic logic [4:0] cs_drive(input logic on, input logic h4,
                                           input logic [1:0] code);
      logic [4:0] v;
      logic [4:0] m;
      v = 5'h00;
      m = 5'h00;
      unique case (code)
         2'h0: m = 5'h07;
         2'h1: m = 5'h03;
         2'h2: m = 5'h00;
         2'h3: m = 5'h1F;
      endcase
      if (on)
      begin
         v = h4 ? 5'h10 : 5'h01;
      end
      return ~(v & m);
   endfunction

   function automatic logic [7:0] seg_mask(input logic [1:0] code);
      logic [7:0] m;
      m = 8'h00;
      unique case (code)
         2'h0: m = 8'h0F;
         2'h1: m = 8'h00;
         2'h2: m = 8'hFF;
         2'h3: m = 8'h03;
      endcase
      return m;
   endfunction

   assign req_hit4 = (req_addr[23:16] == st_ff.win4_base);
   assign sel_hit4 = (st_ff.phase == ebc_pkg::PH_IDLE) ? req_hit4 : st_ff.hit4;
   assign cur_cfg = sel_hit4 ? st_ff.win4 : st_ff.prim;
   assign rdy_act = (st_ff.rdy_s[1] == cur_cfg.rdypol);
   assign strobe_end = cur_cfg.rdyen ? rdy_act : (st_ff.cnt == 4'h0);
   assign bus_sel = wb_cyc_i & wb_stb_i & ~st_ff.ack;

   always_comb
   begin
      logic go_lat_exit;
      logic go_strobe;
      logic gate;
      go_lat_exit = 1'b0;
      go_strobe = 1'b0;
      gate = 1'b0;
      nxt_st = st_ff;
      nxt_st.ea_s = {st_ff.ea_s[0], external_access_pin};
      nxt_st.p0_s = {st_ff.p0_s[0], config_port};
      nxt_st.rdy_s = {st_ff.rdy_s[0], ready_pin};
      nxt_st.done = 1'b0;
      nxt_st.err = 1'b0;
      nxt_st.ack = bus_sel;
      if (bus_sel)
      begin
         nxt_st.rdat = 32'h0000_0000;
         if ({wb_adr_i[15:2], 2'b00} == ebc_pkg::ADDR_PRIMARY)
         begin
            nxt_st.rdat = {16'h0000, st_ff.prim};
            if (wb_we_i)
            begin
               nxt_st.prim = put_cfg(st_ff.prim, wb_dat_i, wb_sel_i);
            end
         end
         else if ({wb_adr_i[15:2], 2'b00} == ebc_pkg::ADDR_WIN4)
         begin
            nxt_st.rdat = {16'h0000, st_ff.win4};
            if (wb_we_i)
            begin
               nxt_st.win4 = put_cfg(st_ff.win4, wb_dat_i, wb_sel_i);
            end
         end
         else if ({wb_adr_i[15:2], 2'b00} == ebc_pkg::ADDR_RESET_CFG)
         begin
            nxt_st.rdat = {24'h000000, st_ff.rcfg};
         end
         else if ({wb_adr_i[15:2], 2'b00} == ebc_pkg::ADDR_WIN4_BASE)
         begin
            nxt_st.rdat = {24'h000000, st_ff.win4_base};
            if (wb_we_i && wb_sel_i[0])
            begin
               nxt_st.win4_base = wb_dat_i[7:0];
            end
         end
      end

      unique case (st_ff.phase)
         ebc_pkg::PH_IDLE:
         begin
            if (req_valid && st_ff.ready)
            begin
               nxt_st.addr = req_addr;
               nxt_st.we = req_we;
               nxt_st.be = req_be;
               nxt_st.wdata = req_wdata;
               nxt_st.hit4 = req_hit4;
               nxt_st.wide = cur_cfg.bus_type_field[1];
               nxt_st.mux = cur_cfg.bus_type_field[0];
               if (!cur_cfg.busact)
               begin
                  nxt_st.done = 1'b1;
                  nxt_st.err = 1'b1;
                  nxt_st.rdata = 16'h0000;
               end
               else
               begin
                  nxt_st.phase = ebc_pkg::PH_LATCH;
                  nxt_st.ale = 1'b1;
                  nxt_st.addr_o = {req_addr[23:16] & seg_mask(st_ff.rcfg.sal), req_addr[15:0]};
                  nxt_st.ad_o = cur_cfg.bus_type_field[0] ? req_addr[15:0] : req_wdata;
                  nxt_st.ad_oe = cur_cfg.bus_type_field[0] | req_we;
                  gate = req_we ? cur_cfg.csw : cur_cfg.csr;
                  nxt_st.cs_n = cs_drive(~gate, req_hit4, st_ff.rcfg.cs);
                  if (st_ff.rcfg.write_strobe_mode_bit)
                  begin
                     nxt_st.bhe_n = ~(req_be[1] & cur_cfg.bus_type_field[1]);
                  end
               end
            end
         end
         ebc_pkg::PH_LATCH:
         begin
            if (cur_cfg.alectl)
            begin
               nxt_st.phase = ebc_pkg::PH_LATCH_LONG;
            end
            else
            begin
               go_lat_exit = 1'b1;
            end
         end
         ebc_pkg::PH_LATCH_LONG:
         begin
            go_lat_exit = 1'b1;
         end
         ebc_pkg::PH_DELAY:
         begin
            go_strobe = 1'b1;
         end
         ebc_pkg::PH_STROBE:
         begin
            if (strobe_end)
            begin
               // Data is qualified by the strobe, so it is taken straight off the pins;
               // a two-stage sampler would miss a zero-wait read entirely
               nxt_st.rdata = st_ff.wide ? ad_in : {8'h00, ad_in[7:0]};
               nxt_st.rd_n = 1'b1;
               nxt_st.wr_n = 1'b1;
               nxt_st.bhe_n = 1'b1;
               nxt_st.cs_n = cs_drive(1'b0, st_ff.hit4, st_ff.rcfg.cs);
               nxt_st.ad_oe = 1'b0;
               if (!cur_cfg.mttc)
               begin
                  nxt_st.phase = ebc_pkg::PH_TRI;
               end
               else
               begin
                  nxt_st.phase = ebc_pkg::PH_IDLE;
                  nxt_st.done = 1'b1;
               end
            end
            else if (!cur_cfg.rdyen)
            begin
               nxt_st.cnt = st_ff.cnt - 4'h1;
            end
         end
         ebc_pkg::PH_TRI:
         begin
            nxt_st.phase = ebc_pkg::PH_IDLE;
            nxt_st.done = 1'b1;
         end
         default:
         begin
            nxt_st.phase = ebc_pkg::PH_IDLE;
         end
      endcase

      if (go_lat_exit)
      begin
         nxt_st.ale = 1'b0;
         if (st_ff.mux)
         begin
            nxt_st.ad_o = st_ff.wdata;
            nxt_st.ad_oe = st_ff.we;
         end
         if (cur_cfg.rwdc)
         begin
            go_strobe = 1'b1;
         end
         else
         begin
            nxt_st.phase = ebc_pkg::PH_DELAY;
         end
      end
      if (go_strobe)
      begin
         nxt_st.phase = ebc_pkg::PH_STROBE;
         nxt_st.cnt = ebc_pkg::WAIT_MAX - cur_cfg.cycle_wait_field;
         nxt_st.rd_n = st_ff.we;
         nxt_st.cs_n = cs_drive(1'b1, st_ff.hit4, st_ff.rcfg.cs);
         if (st_ff.rcfg.write_strobe_mode_bit)
         begin
            nxt_st.wr_n = ~st_ff.we;
         end
         else
         begin
            nxt_st.wr_n = ~(st_ff.we & st_ff.be[0]);
            nxt_st.bhe_n = ~(st_ff.we & st_ff.be[1] & st_ff.wide);
         end
      end
      nxt_st.ready = (nxt_st.phase == ebc_pkg::PH_IDLE);

      // Sync reset loads the straps continuously, so the last sampled value stands
      if (!reset_n)
      begin
         nxt_st.ack = 1'b0;
         nxt_st.rdat = 32'h0000_0000;
         nxt_st.win4 = ebc_pkg::WIN4_RESET;
         nxt_st.win4_base = ebc_pkg::WIN4_BASE_RESET;
         nxt_st.phase = ebc_pkg::PH_IDLE;
         nxt_st.cnt = 4'h0;
         nxt_st.addr = 24'h000000;
         nxt_st.we = 1'b0;
         nxt_st.be = 2'h0;
         nxt_st.wdata = 16'h0000;
         nxt_st.hit4 = 1'b0;
         nxt_st.wide = 1'b0;
         nxt_st.mux = 1'b0;
         nxt_st.ready = 1'b0;
         nxt_st.done = 1'b0;
         nxt_st.err = 1'b0;
         nxt_st.rdata = 16'h0000;
         nxt_st.ale = 1'b0;
         nxt_st.rd_n = 1'b1;
         nxt_st.wr_n = 1'b1;
         nxt_st.bhe_n = 1'b1;
         nxt_st.cs_n = 5'h1F;
         nxt_st.addr_o = 24'h000000;
         nxt_st.ad_o = 16'h0000;
         nxt_st.ad_oe = 1'b0;
         if (st_ff.ea_s[1])
         begin
            nxt_st.prim = ebc_pkg::PRIM_RESET_EA_HIGH;
         end
         else
         begin
            nxt_st.prim = ebc_pkg::PRIM_RESET_EA_HIGH;
            nxt_st.prim.busact = 1'b1;
            nxt_st.prim.alectl = 1'b1;
            nxt_st.prim.bus_type_field = st_ff.p0_s[1][ebc_pkg::P0_BUS_TYPE_FIELD_LSB +: 2];
         end
         nxt_st.rcfg[4:0] = st_ff.p0_s[1][ebc_pkg::P0_RCFG_LSB +: 5];
         if (hw_long_reset)
         begin
            nxt_st.rcfg.clk = st_ff.p0_s[1][ebc_pkg::P0_CLK_LSB +: 3];
         end
      end
      nxt_st.clk_x2 = ebc_pkg::clk_x2(nxt_st.rcfg.clk);
   end

   always_ff @(posedge clk_sys)
   begin
      st_ff <= nxt_st;
   end

   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdat;
   assign req_ready = st_ff.ready;
   assign req_done = st_ff.done;
   assign req_err = st_ff.err;
   assign req_rdata = st_ff.rdata;
   assign ad_out = st_ff.ad_o;
   assign ad_oe = st_ff.ad_oe;
   assign addr_out = st_ff.addr_o;
   assign ale = st_ff.ale;
   assign rd_n = st_ff.rd_n;
   assign wr_n = st_ff.wr_n;
   assign bhe_n = st_ff.bhe_n;
   assign cs_n = st_ff.cs_n;
   assign bus_wide = st_ff.wide;
   assign bus_mux = st_ff.mux;
   assign cpu_clock_x2 = st_ff.clk_x2;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   property p_wait_load;
      (st_ff.phase == ebc_pkg::PH_STROBE) && ($past(st_ff.phase) != ebc_pkg::PH_STROBE)
         |-> (st_ff.cnt == 4'hF - $past(cur_cfg.cycle_wait_field));
   endproperty
   a_wait_load: assert property (p_wait_load) else $error("wait count wrong");
   property p_delay;
      ((st_ff.phase == ebc_pkg::PH_LATCH_LONG) && !cur_cfg.rwdc)
         |=> (st_ff.phase == ebc_pkg::PH_DELAY) && st_ff.rd_n ##1 st_ff.phase == ebc_pkg::PH_STROBE;
   endproperty
   a_delay: assert property (p_delay) else $error("rw delay missing");
   property p_tri;
      (st_ff.phase == ebc_pkg::PH_STROBE) && strobe_end && !cur_cfg.mttc
         |=> !st_ff.done ##1 st_ff.done;
   endproperty
   a_tri: assert property (p_tri) else $error("turnaround wait wrong");
   property p_ale_long;
      (st_ff.phase == ebc_pkg::PH_LATCH) && cur_cfg.alectl |=> st_ff.ale [*1] ##1 !st_ff.ale;
   endproperty
   a_ale_long: assert property (p_ale_long) else $error("latch strobe not lengthened");
   property p_refuse;
      req_valid && st_ff.ready && !cur_cfg.busact
         |=> st_ff.done && st_ff.err && st_ff.ale == 1'b0 && st_ff.ready;
   endproperty
   a_refuse: assert property (p_refuse) else $error("disabled window ran a cycle");
   property p_ready_hold;
      (st_ff.phase == ebc_pkg::PH_STROBE) && cur_cfg.rdyen && !rdy_act
         |=> (st_ff.phase == ebc_pkg::PH_STROBE) && !st_ff.done;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("cycle ended without ready");
   property p_rd_gate;
      (st_ff.phase == ebc_pkg::PH_DELAY) && cur_cfg.csr && !st_ff.we |-> (st_ff.cs_n == 5'h1F);
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("chip select outside read");
   property p_wrl;
      (st_ff.phase == ebc_pkg::PH_STROBE) && st_ff.we && !st_ff.rcfg.write_strobe_mode_bit && !st_ff.be[0]
         |-> st_ff.wr_n;
   endproperty
   a_wrl: assert property (p_wrl) else $error("low byte strobe on high byte write");
   property p_rcfg_ro;
      bus_sel && wb_we_i && ({wb_adr_i[15:2], 2'b00} == ebc_pkg::ADDR_RESET_CFG)
         |=> $stable(st_ff.rcfg);
   endproperty
   a_rcfg_ro: assert property (p_rcfg_ro) else $error("reset config written");
   property p_rsv;
      !st_ff.prim.rsv8 && !st_ff.prim.rsv11 && !st_ff.win4.rsv8 && !st_ff.win4.rsv11;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   c_wait: cover property ((st_ff.phase == ebc_pkg::PH_STROBE) && !cur_cfg.rdyen ##1 st_ff.done);
   c_ready: cover property ((st_ff.phase == ebc_pkg::PH_STROBE) && cur_cfg.rdyen && rdy_act);
   c_win4: cover property (st_ff.hit4 && (st_ff.phase == ebc_pkg::PH_STROBE));
   c_refuse: cover property (st_ff.done && st_ff.err);
endmodule // external_bus_config

// ===== rtl/ebc_pkg.sv
package ebc_pkg;
   localparam logic [15:0] ADDR_PRIMARY = 16'hF100;
   localparam logic [15:0] ADDR_WIN4 = 16'hF104;
   localparam logic [15:0] ADDR_RESET_CFG = 16'hF108;
   localparam logic [15:0] ADDR_WIN4_BASE = 16'hF10C;
   localparam int CYCLE_WAIT_FIELD_LSB = 0;
   localparam int RWDC_POS = 4;
   localparam int MTTC_POS = 5;
   localparam int BUS_TYPE_FIELD_LSB = 6;
   localparam int ALECTL_POS = 9;
   localparam int BUSACT_POS = 10;
   localparam int RDYEN_POS = 12;
   localparam int RDYPOL_POS = 13;
   localparam int CSREN_POS = 14;
   localparam int CSWEN_POS = 15;
   localparam logic [15:0] CFG_MASK = 16'hF6FF;
   localparam logic [15:0] PRIM_RESET_EA_HIGH = 16'h0000;
   localparam logic [15:0] WIN4_RESET = 16'h0000;
   localparam logic [7:0] WIN4_BASE_RESET = 8'h00;
   localparam logic [3:0] WAIT_MAX = 4'hF;
   localparam int P0_BUS_TYPE_FIELD_LSB = 6;
   localparam int P0_RCFG_LSB = 8;
   localparam int P0_CLK_LSB = 13;

   typedef struct packed {
      logic csw;
      logic csr;
      logic rdypol;
      logic rdyen;
      logic rsv11;
      logic busact;
      logic alectl;
      logic rsv8;
      logic [1:0] bus_type_field;
      logic mttc;
      logic rwdc;
      logic [3:0] cycle_wait_field;
   } bus_cfg_t;

   typedef struct packed {
      logic [2:0] clk;
      logic [1:0] sal;
      logic [1:0] cs;
      logic write_strobe_mode_bit;
   } reset_cfg_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_LATCH = 3'b001,
      PH_LATCH_LONG = 3'b010,
      PH_DELAY = 3'b011,
      PH_STROBE = 3'b100,
      PH_TRI = 3'b101
   } phase_t;

   // CPU clock over oscillator, times two, so the 0.5 ratio stays an integer
   function automatic logic [5:0] clk_x2(input logic [2:0] code);
      logic [5:0] r;
      r = 6'h00;
      unique case (code)
         3'h0: r = 6'h20;
         3'h1: r = 6'h01;
         3'h2: r = 6'h14;
         3'h3: r = 6'h02;
         3'h4: r = 6'h0A;
         3'h5: r = 6'h10;
         3'h6: r = 6'h06;
         3'h7: r = 6'h08;
      endcase
      return r;
   endfunction
endpackage

// ===== testbench/ext_mem_model.sv
module ext_mem_model (
   input wire logic clk_sys,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [23:0] addr_out,
   input wire logic [15:0] ad_out,
   input wire logic rdy_pol,
   input wire logic [3:0] rdy_dly,
   output logic [15:0] ad_in,
   output logic ready_pin,
   output logic [15:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] addr_ff = 8'h00;
   logic [15:0] last_ff = 16'h0000;
   logic [3:0] cnt_ff = 4'h0;
   logic act_ff = 1'b0;
   logic str_ff = 1'b0;
   logic [7:0] a8;
   logic drv;
   assign a8 = ale ? addr_out[7:0] : addr_ff;
   // Data driven from address latch until one cycle after the strobe ends, so a late sampler still sees it
   assign drv = (ale | act_ff) & wr_n;
   // Released lines show the inverse of the last value, a stale sample cannot match
   assign ad_in = drv ? {a8 ^ 8'hA5, a8} : ~last_ff;
   // Ready stays at the inactive level until the strobe has lasted rdy_dly cycles
   assign ready_pin = (cnt_ff >= rdy_dly) ? rdy_pol : ~rdy_pol;
   always_ff @(posedge clk_sys)
   begin
      if (ale)
         addr_ff <= addr_out[7:0];
      if (drv)
         last_ff <= ad_in;
      if (!wr_n)
         wr_data <= ad_out;
      str_ff <= !rd_n | !wr_n;
      act_ff <= ale | (act_ff & ~(str_ff & rd_n & wr_n));
      cnt_ff <= (!rd_n || !wr_n) ? cnt_ff + 4'h1 : 4'h0;
   end
endmodule // ext_mem_model

// ===== testbench/external_bus_config_tb.sv
module external_bus_config_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [15:0] cfg;
      logic we;
      logic [7:0] n_ale;
      logic [7:0] n_str;
      logic [7:0] lat;
   } row_t;
   logic clk_sys = 1'b0, reset_n = 1'b0, hw_long_reset = 1'b1, external_access_pin = 1'b0;
   logic [15:0] config_port = 16'hFF00;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [3:0] wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic req_valid = 1'b0, req_we = 1'b0, req_ready, req_done, req_err, err;
   logic [23:0] req_addr = 24'h0, addr_out, cap_addr;
   logic [1:0] req_be = 2'h3;
   logic [15:0] req_wdata = 16'h0, req_rdata, rdata, ad_in, ad_out, wr_data;
   logic ready_pin, ad_oe, ale, rd_n, wr_n, bhe_n, bus_wide, bus_mux;
   logic rdy_pol = 1'b0;
   logic [4:0] cs_n;
   logic [5:0] cpu_clock_x2;
   logic [7:0] c_ale, c_rd, c_wr, c_bhe, c_cs0, c_cs4, c_lat, a8;
   int n_fail = 0, check_count = 0;
   logic [5:0] ratio [8] = '{6'h20, 6'h01, 6'h14, 6'h02, 6'h0A, 6'h10, 6'h06, 6'h08};
   logic [7:0] seg_mask [4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};
   row_t rows [6] = '{
      '{16'h04BF, 1'b0, 8'h01, 8'h01, 8'h03},
      '{16'h04B0, 1'b1, 8'h01, 8'h10, 8'h12},
      '{16'h068E, 1'b0, 8'h02, 8'h02, 8'h07},
      '{16'h047F, 1'b0, 8'h01, 8'h01, 8'h03},
      '{16'h44ED, 1'b0, 8'h01, 8'h03, 8'h06},
      '{16'h84BF, 1'b1, 8'h01, 8'h01, 8'h03}};

   external_bus_config external_bus_config_i (.clk_sys, .reset_n, .hw_long_reset,
      .external_access_pin, .config_port, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .req_valid, .req_addr, .req_we, .req_be,
      .req_wdata, .req_ready, .req_done, .req_err, .req_rdata, .ready_pin, .ad_in, .ad_out,
      .ad_oe, .addr_out, .ale, .rd_n, .wr_n, .bhe_n, .cs_n, .bus_wide, .bus_mux,
      .cpu_clock_x2);
   ext_mem_model ext_mem_model_i (.clk_sys, .ale, .rd_n, .wr_n, .addr_out, .ad_out,
      .rdy_pol, .rdy_dly(4'h5), .ad_in, .ready_pin, .wr_data);

   task automatic complete_run();
      if (n_fail == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask

   // Entered right after an edge; holds the request until ack is sampled high
   task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 50)
         n_fail++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Counts strobe and select cycles between take and done
   task automatic ext(input logic [23:0] a, input logic we, input logic [1:0] be,
      input logic [15:0] wd);
      int n;
      n = 0;
      {c_ale, c_rd, c_wr, c_bhe, c_cs0, c_cs4, c_lat} = '0;
      req_addr <= a;
      req_we <= we;
      req_be <= be;
      req_wdata <= wd;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      while (req_ready !== 1'b1 && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      req_valid <= 1'b0;
      while (c_lat < 8'hC8)
      begin
         @(posedge clk_sys);
         c_lat++;
         c_ale += ale;
         c_rd += !rd_n;
         c_wr += !wr_n;
         c_bhe += !bhe_n;
         c_cs0 += !cs_n[0];
         c_cs4 += !cs_n[4];
         if (ale === 1'b1)
            cap_addr = addr_out;
         if (req_done === 1'b1)
            break;
      end
      rdata = req_rdata;
      err = req_err;
   endtask

   task automatic do_reset(input logic [15:0] cp, input logic ea, input logic lng);
      reset_n <= 1'b0;
      config_port <= cp;
      external_access_pin <= ea;
      hw_long_reset <= lng;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
   endtask

   initial
   begin
      forever #25 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (10000) @(posedge clk_sys);
      n_fail++;
      complete_run();
   end

   initial
   begin
      @(posedge clk_sys);
      do_reset(16'hFF00, 1'b0, 1'b1);
      wb(1'b1, ebc_pkg::ADDR_WIN4_BASE, 32'h12);
      foreach (rows[i])
      begin
         a8 = 8'h30 + i[7:0];
         wb(1'b1, ebc_pkg::ADDR_WIN4, {16'h0, rows[i].cfg});
         ext({16'h1200, a8}, rows[i].we, 2'h3, 16'hC35A ^ i[15:0]);
         chk("lat", rows[i].lat, c_lat);
         chk("ale", rows[i].n_ale, c_ale);
         chk("strobe", rows[i].n_str, rows[i].we ? c_wr : c_rd);
         chk("wide", rows[i].cfg[7], bus_wide);
         chk("mux", rows[i].cfg[6], bus_mux);
         if (rows[i].cfg[14])
            chk("rdgate", c_rd, c_cs4);
         else if (rows[i].cfg[15])
            chk("wrgate", c_wr, c_cs4);
         else
            chk("csfree", 1, c_cs4 > rows[i].n_str);
         if (rows[i].we)
         begin
            chk("wdata", 16'hC35A ^ i[15:0], wr_data);
            chk("bhe", 1, c_bhe != 0);
         end
         else
            chk("rdata", rows[i].cfg[7] ? {a8 ^ 8'hA5, a8} : {8'h00, a8}, rdata);
      end
      wb(1'b1, ebc_pkg::ADDR_WIN4, 32'hFFFF);
      wb(1'b0, ebc_pkg::ADDR_WIN4, 32'h0);
      chk("reserved", 32'hF6FF, rd);
      wb(1'b1, ebc_pkg::ADDR_RESET_CFG, 32'h0);
      wb(1'b0, ebc_pkg::ADDR_RESET_CFG, 32'h0);
      chk("rcfg_ro", 32'hFF, rd);
      wb(1'b1, 16'hF110, 32'h1234);
      wb(1'b0, 16'hF110, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, ebc_pkg::ADDR_WIN4, 32'h00BF);
      ext(24'h120040, 1'b0, 2'h3, 16'h0);
      chk("err", 1, err);
      chk("errlat", 1, c_lat);
      chk("noale", 0, c_ale);
      for (int p = 0; p < 2; p++)
      begin
         rdy_pol <= p[0];
         wb(1'b1, ebc_pkg::ADDR_WIN4, p[0] ? 32'h34BF : 32'h14BF);
         ext(24'h120041, 1'b0, 2'h3, 16'h0);
         chk("ready", 1, c_rd >= 5 && c_rd <= 9);
      end
      // Each strap code needs its own reset, the register cannot be written
      for (int k = 0; k < 8; k++)
      begin
         do_reset({k[2:0], k[1:0], k[1:0], 1'b1, k[1:0], 6'h00}, 1'b0, 1'b1);
         wb(1'b0, ebc_pkg::ADDR_RESET_CFG, 32'h0);
         chk("rcfg", {k[2:0], k[1:0], k[1:0], 1'b1}, rd);
         chk("ratio", ratio[k], cpu_clock_x2);
         wb(1'b0, ebc_pkg::ADDR_PRIMARY, 32'h0);
         chk("prim", {5'h00, 2'h3, 1'b0, k[1:0], 6'h00}, rd);
         ext(24'hAB0010, 1'b0, 2'h3, 16'h0);
         chk("seg", 8'hAB & seg_mask[k[1:0]], cap_addr[23:16]);
         chk("cs0", k[1:0] != 2'h2, c_cs0 != 0);
      end
      do_reset(16'h0000, 1'b1, 1'b0);
      wb(1'b0, ebc_pkg::ADDR_RESET_CFG, 32'h0);
      chk("short", 32'hE0, rd);
      chk("ratio_hold", 6'h08, cpu_clock_x2);
      wb(1'b0, ebc_pkg::ADDR_PRIMARY, 32'h0);
      chk("prim_ea", 32'h0, rd);
      wb(1'b1, ebc_pkg::ADDR_WIN4_BASE, 32'h12);
      wb(1'b1, ebc_pkg::ADDR_WIN4, 32'h04BF);
      ext(24'h120050, 1'b1, 2'h1, 16'h00AA);
      chk("split_lo", 1, c_wr != 0 && c_bhe == 0);
      chk("cs4_off", 0, c_cs4);
      ext(24'h120051, 1'b1, 2'h2, 16'hBB00);
      chk("split_hi", 1, c_bhe != 0 && c_wr == 0);
      complete_run();
   end
endmodule // external_bus_config_tb
